// file: dio_cfg.svh
// offsets, field positions, reset values and timing figures of the digital i/o ports
`ifndef DIO_CFG_SVH
`define DIO_CFG_SVH

// register indices; the byte address on the bus is four times the index
`define DIO_P1_BASE 6'h20
`define DIO_P2_BASE 6'h28
`define DIO_P3_BASE 6'h18
`define DIO_P4_BASE 6'h1C
`define DIO_P5_BASE 6'h30
`define DIO_P6_BASE 6'h34
`define DIO_GIE_IDX 6'h38

// offsets inside one port's group
`define DIO_OFF_IN 3'h0
`define DIO_OFF_OUT 3'h1
`define DIO_OFF_DIR 3'h2
`define DIO_OFF_IFG 3'h3
`define DIO_OFF_IES 3'h4
`define DIO_OFF_IE 3'h5
`define DIO_OFF_SEL_IRQ 3'h6
`define DIO_OFF_SEL_PLAIN 3'h3
`define DIO_SPAN_IRQ 6'h07
`define DIO_SPAN_PLAIN 6'h04

// counts
`define DIO_NPORTS 6
`define DIO_NIRQ 2
`define DIO_GIE_BIT 0

// reset values
`define DIO_RST_OUT 8'h00
`define DIO_RST_DIR 8'h00
`define DIO_RST_SEL 8'h00
`define DIO_RST_IFG 8'h00
`define DIO_RST_IES 8'h00
`define DIO_RST_IE 8'h00
`define DIO_RST_GIE 1'h0

// shortest pin event the source must hold, tenths of a clock period
`define DIO_MIN_EVENT_TENTHS 15

`endif

// file: dio_pkg.sv
// types shared by the digital i/o ports
`default_nettype none
package dio_pkg;

  // one port's eight pads as seen from the pin side
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe_b;
  } dio_pad_type;

  // decoded register access
  typedef struct packed {
    logic hit;
    logic global_interrupt_enable;
    logic [2:0] port;
    logic [2:0] off;
  } dio_dec_type;

endpackage : dio_pkg
`default_nettype wire

// file: dio_ports.sv
// six eight-bit digital i/o ports with edge interrupts on ports one and two
`timescale 1ns/10ps
`default_nettype none
`include "dio_cfg.svh"

module dio_ports (
  input wire logic sys_clk_i,                         // system clock
  input wire logic rst_b_i,                           // sync reset, low
  input wire logic wb_cyc_i,                          // wishbone cycle
  input wire logic wb_stb_i,                          // wishbone strobe
  input wire logic wb_we_i,                           // wishbone write
  input wire logic [31:0] wb_adr_i,                   // byte address
  input wire logic [3:0] wb_sel_i,                    // byte enables
  input wire logic [31:0] wb_dat_i,                   // write data
  output logic [31:0] wb_dat_o,                       // read data
  output logic wb_ack_o,                              // acknowledge
  input wire logic [5:0][7:0] pin_in_i,               // pad levels
  output dio_pkg::dio_pad_type [5:0] pad_o,           // pad drive
  input wire logic [5:0][7:0] periph_out_i,           // peripheral drive
  output logic [5:0][7:0] periph_in_o,                // peripheral input
  output logic irq_port_one_o,                        // port one request
  output logic irq_port_two_o                         // port two request
);

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  localparam logic [5:0] BASE [`DIO_NPORTS] = '{`DIO_P1_BASE, `DIO_P2_BASE,
    `DIO_P3_BASE, `DIO_P4_BASE, `DIO_P5_BASE, `DIO_P6_BASE};

  // ==========================================================
  // state
  logic [5:0][7:0] out_q;
  logic [5:0][7:0] dir_q;
  logic [5:0][7:0] fsel_q;
  logic [1:0][7:0] flag_q;
  logic [1:0][7:0] ies_q;
  logic [1:0][7:0] ie_q;
  logic gie_q;
  logic [5:0][7:0] sync1_q;
  logic [5:0][7:0] sync2_q;
  logic [1:0][7:0] prev_q;
  logic [5:0][7:0] periph_q;
  dio_pkg::dio_pad_type [5:0] pad_q;
  logic irq_one_q;
  logic irq_two_q;
  logic ack_q;
  logic [31:0] rdat_q;
  dio_pkg::dio_dec_type dec;
  logic [5:0] idx;
  logic [5:0] off6;
  logic access;
  logic wr;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [1:0][7:0] edge_hit;
  logic [1:0][7:0] pend;

  // ==========================================================
  // wishbone decode
  always_comb begin
    dec = '0;
    off6 = 6'h00;
    idx = wb_adr_i[7:2];
    for (int p = 0; p < `DIO_NPORTS; p++) begin
      off6 = idx - BASE[p];
      if (off6 < ((p < `DIO_NIRQ) ? `DIO_SPAN_IRQ : `DIO_SPAN_PLAIN)) begin
        dec.hit = 1'b1;
        dec.port = 3'(p);
        dec.off = off6[2:0];
      end
    end
    if (idx == `DIO_GIE_IDX) begin
      dec.hit = 1'b1;
      dec.global_interrupt_enable = 1'b1;
    end
    // words outside the map answer zero and ignore writes
    if (wb_adr_i[31:8] != 24'h000000 || wb_adr_i[1:0] != 2'h0) begin
      dec = '0;
    end
  end

  assign access = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = access & wb_we_i & wb_sel_i[0] & dec.hit;
  assign wbyte = wb_dat_i[7:0];

  // one wait-free answer: ack the cycle after the request appears
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access;
    end
  end

  always_comb begin
    rbyte = 8'h00;
    if (dec.global_interrupt_enable) begin
      rbyte[`DIO_GIE_BIT] = gie_q;
    end else if (dec.hit) begin
      case (dec.off)
        `DIO_OFF_IN: rbyte = sync2_q[dec.port];
        `DIO_OFF_OUT: rbyte = out_q[dec.port];
        `DIO_OFF_DIR: rbyte = dir_q[dec.port];
        `DIO_OFF_IFG: begin
          if (dec.port < 3'h2) begin
            rbyte = flag_q[dec.port[0]];
          end else begin
            rbyte = fsel_q[dec.port];
          end
        end
        `DIO_OFF_IES: rbyte = ies_q[dec.port[0]];
        `DIO_OFF_IE: rbyte = ie_q[dec.port[0]];
        `DIO_OFF_SEL_IRQ: rbyte = fsel_q[dec.port];
        default: rbyte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rdat_q <= 32'h00000000;
    end else if (access) begin
      rdat_q <= {24'h000000, rbyte};
    end
  end

  // ==========================================================
  // port configuration registers, all six ports
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      for (int p = 0; p < `DIO_NPORTS; p++) begin
        out_q[p] <= `DIO_RST_OUT;
        dir_q[p] <= `DIO_RST_DIR;
        fsel_q[p] <= `DIO_RST_SEL;
      end
    end else if (wr && !dec.global_interrupt_enable) begin
      if (dec.off == `DIO_OFF_OUT) begin
        out_q[dec.port] <= wbyte;
      end
      if (dec.off == `DIO_OFF_DIR) begin
        dir_q[dec.port] <= wbyte;
      end
      // selecting a function leaves direction alone
      if ((dec.port < 3'h2 && dec.off == `DIO_OFF_SEL_IRQ) ||
          (dec.port >= 3'h2 && dec.off == `DIO_OFF_SEL_PLAIN)) begin
        fsel_q[dec.port] <= wbyte;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      gie_q <= `DIO_RST_GIE;
    end else if (wr && dec.global_interrupt_enable) begin
      gie_q <= wbyte[`DIO_GIE_BIT];
    end
  end

  // ==========================================================
  // pin synchronisers; short glitches under one period may be missed
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= pin_in_i;
      sync2_q <= sync1_q;
      prev_q <= sync2_q[1:0];
    end
  end

  // peripheral input is latched so deselecting freezes it
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      periph_q <= '0;
    end else begin
      for (int p = 0; p < `DIO_NPORTS; p++) begin
        periph_q[p] <= (fsel_q[p] & sync2_q[p]) |
                       (~fsel_q[p] & periph_q[p]);
      end
    end
  end

  // pad drivers; on unselected pins the level follows out or direction writes, and any
  // edge that causes on ports one and two is caught by the flag logic like an external one
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      for (int p = 0; p < `DIO_NPORTS; p++) begin
        pad_q[p].level <= 8'h00;
        pad_q[p].oe_b <= 8'hFF;
      end
    end else begin
      for (int p = 0; p < `DIO_NPORTS; p++) begin
        pad_q[p].level <= (fsel_q[p] & periph_out_i[p]) |
                          (~fsel_q[p] & out_q[p]);
        pad_q[p].oe_b <= ~dir_q[p];
      end
    end
  end

  // ==========================================================
  // edge flags, ports one and two only
  always_comb begin
    for (int p = 0; p < `DIO_NIRQ; p++) begin
      // edge select only steers detection; changing it alone sets nothing
      edge_hit[p] = ((~ies_q[p] & sync2_q[p] & ~prev_q[p]) |
                     (ies_q[p] & ~sync2_q[p] & prev_q[p])) &
                    ~fsel_q[p];
      pend[p] = flag_q[p] & ie_q[p] & ~fsel_q[p];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      flag_q <= '0;
      ies_q <= '0;
      ie_q <= '0;
      for (int p = 0; p < `DIO_NIRQ; p++) begin
        flag_q[p] <= `DIO_RST_IFG;
        ies_q[p] <= `DIO_RST_IES;
        ie_q[p] <= `DIO_RST_IE;
      end
    end else begin
      for (int p = 0; p < `DIO_NIRQ; p++) begin
        // a hardware edge in the clearing cycle still lands
        if (wr && !dec.global_interrupt_enable && dec.port == 3'(p) &&
            dec.off == `DIO_OFF_IFG) begin
          flag_q[p] <= wbyte | edge_hit[p];
        end else begin
          flag_q[p] <= flag_q[p] | edge_hit[p];
        end
        if (wr && !dec.global_interrupt_enable && dec.port == 3'(p) &&
            dec.off == `DIO_OFF_IES) begin
          ies_q[p] <= wbyte;
        end
        if (wr && !dec.global_interrupt_enable && dec.port == 3'(p) &&
            dec.off == `DIO_OFF_IE) begin
          ie_q[p] <= wbyte;
        end
      end
    end
  end

  // level requests: a flag left pending keeps asking after service
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      irq_one_q <= 1'b0;
      irq_two_q <= 1'b0;
    end else begin
      irq_one_q <= gie_q & (|pend[0]);
      irq_two_q <= gie_q & (|pend[1]);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign pad_o = pad_q;
  assign periph_in_o = periph_q;
  assign irq_port_one_o = irq_one_q;
  assign irq_port_two_o = irq_two_q;

  // ==========================================================
  // checks
  chk_sync_two_stage: assert property (
    ##2 sync2_q == $past(pin_in_i, 2))
    else $error("input register not two cycles behind pin");

  chk_rise_sets_flag: assert property (
    (!ies_q[0][1] && !fsel_q[0][1] && sync2_q[0][1] && !prev_q[0][1])
    |=> flag_q[0][1])
    else $error("rising edge did not set port one flag");

  chk_fall_sets_flag: assert property (
    (ies_q[1][0] && !fsel_q[1][0] && !sync2_q[1][0] && prev_q[1][0])
    |=> flag_q[1][0])
    else $error("falling edge did not set port two flag");

  chk_flag_sticky: assert property (
    (flag_q[0][1] && !(wr && dec.port == 3'h0 && dec.off == `DIO_OFF_IFG))
    |=> flag_q[0][1])
    else $error("port one flag cleared without a write");

  chk_sel_blocks_irq: assert property (
    ((flag_q[0] & ie_q[0] & ~fsel_q[0]) == 8'h00) |=> !irq_port_one_o)
    else $error("request from a pin given to a peripheral");

  chk_irq_needs_gie: assert property (
    irq_port_two_o |-> $past(gie_q) && ($past(flag_q[1] & ie_q[1]) != 8'h00))
    else $error("port two request without enabled pending flag");

  chk_periph_holds: assert property (
    (fsel_q[4] == 8'h00) ##1 (fsel_q[4] == 8'h00) |-> $stable(periph_in_o[4]))
    else $error("peripheral input moved while deselected");

  chk_dir_to_oe: assert property (
    ##1 pad_o[3].oe_b == ~$past(dir_q[3]))
    else $error("output enable does not follow direction");

  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");

endmodule : dio_ports
`default_nettype wire

// file: dio_pin_env.sv
// pin environment model: each pad is driven by the ports or by an outside source
`timescale 1ns/10ps
`default_nettype none

module dio_pin_env (
  input wire dio_pkg::dio_pad_type [5:0] pad_i, // pad drive from the ports
  input wire logic [5:0][7:0] ext_level_i,      // outside source levels
  output logic [5:0][7:0] pin_o                 // resolved pin levels
);
  // ==========================================================
  // pad resolution
  // the outside source drives every released pad, so a released pad never floats
  always_comb begin
    for (int p = 0; p < 6; p++) begin
      pin_o[p] = (pad_i[p].oe_b & ext_level_i[p]) |
                 (~pad_i[p].oe_b & pad_i[p].level);
    end
  end
endmodule : dio_pin_env
`default_nettype wire

// file: dio_tb.sv
// self-checking bench for the six digital i/o ports
`timescale 1ns/10ps
`default_nettype none
`include "dio_cfg.svh"

module testbench;
  logic sys_clk, rst_b, cyc, stb, we, ack, irq1, irq2;
  logic [31:0] adr, wdat, rdat;
  logic [3:0] sel;
  logic [5:0][7:0] pin_lvl, ext, pout, pin_periph;
  dio_pkg::dio_pad_type [5:0] pad;
  logic [7:0] q;
  int mismatches, checks;

  // ==========================================================
  // clock and instances
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  dio_ports dut_u (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_in_i(pin_lvl),
    .pad_o(pad), .periph_out_i(pout), .periph_in_o(pin_periph),
    .irq_port_one_o(irq1), .irq_port_two_o(irq2));

  dio_pin_env env_u (.pad_i(pad), .ext_level_i(ext), .pin_o(pin_lvl));

  // ==========================================================
  // shared tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string m);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk8

  // classic cycle; the request stands until ack is sampled high or 20 clocks pass
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= {24'h000000, idx, 2'h0};
    wdat <= {24'h000000, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    if (ack !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: no bus ack", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp, input string m);
    bus(1'b0, idx, 8'h00);
    chk8(q, exp, m);
  endtask : rdchk

  function automatic logic [5:0] rix(input int p, input logic [2:0] off);
    logic [5:0] b;
    case (p)
      0: b = `DIO_P1_BASE;
      1: b = `DIO_P2_BASE;
      2: b = `DIO_P3_BASE;
      3: b = `DIO_P4_BASE;
      4: b = `DIO_P5_BASE;
      default: b = `DIO_P6_BASE;
    endcase
    return b + {3'h0, off};
  endfunction : rix

  function automatic logic [5:0] six(input int p);
    return rix(p, (p < 2) ? `DIO_OFF_SEL_IRQ : `DIO_OFF_SEL_PLAIN);
  endfunction : six

  task automatic setx(input int p, input logic [7:0] v);
    @(posedge sys_clk);
    ext[p] <= v;
    repeat (5) @(posedge sys_clk);
  endtask : setx

  // ==========================================================
  // scenarios
  task automatic t_reset;
    for (int p = 0; p < 6; p++) begin
      rdchk(rix(p, `DIO_OFF_DIR), 8'h00, "dir rst");
      rdchk(six(p), 8'h00, "sel rst");
      chk8(pad[p].oe_b, 8'hFF, "oe rst");
    end
    rdchk(rix(0, `DIO_OFF_IFG), 8'h00, "ifg rst");
    rdchk(6'h10, 8'h00, "unmapped");
    rdchk(6'h27, 8'h00, "gap");
  endtask : t_reset

  task automatic t_ports;
    for (int p = 0; p < 6; p++) begin
      bus(1'b1, rix(p, `DIO_OFF_OUT), 8'hA5 ^ p[7:0]);
      bus(1'b1, rix(p, `DIO_OFF_DIR), 8'hF0);
      bus(1'b1, rix(p, `DIO_OFF_IN), 8'hFF);
      repeat (4) @(posedge sys_clk);
      chk8(pad[p].oe_b, 8'h0F, "oe dir");
      chk8(pad[p].level & 8'hF0, (8'hA5 ^ p[7:0]) & 8'hF0, "pad lvl");
      rdchk(rix(p, `DIO_OFF_IN), (8'hA5 ^ p[7:0]) & 8'hF0, "in");
      rdchk(rix(p, `DIO_OFF_OUT), 8'hA5 ^ p[7:0], "out rw");
      bus(1'b1, rix(p, `DIO_OFF_DIR), 8'h00);
    end
  endtask : t_ports

  task automatic t_edges(input int p);
    logic [7:0] me;
    me = (p == 0) ? 8'h01 : 8'h02;
    bus(1'b1, `DIO_GIE_IDX, 8'h01);
    bus(1'b1, rix(p, `DIO_OFF_IES), 8'h01);
    bus(1'b1, rix(p, `DIO_OFF_IFG), 8'h00);
    bus(1'b1, rix(p, `DIO_OFF_IE), 8'h03);
    setx(p, 8'h03);
    rdchk(rix(p, `DIO_OFF_IFG), 8'h02, "rise");
    chk8({6'h00, irq2, irq1}, me, "irq line");
    bus(1'b1, rix(p, `DIO_OFF_IFG), 8'h00);
    repeat (3) @(posedge sys_clk);
    chk8({6'h00, irq2, irq1}, 8'h00, "static");
    rdchk(rix(p, `DIO_OFF_IFG), 8'h00, "static ifg");
    setx(p, 8'h00);
    rdchk(rix(p, `DIO_OFF_IFG), 8'h01, "fall");
    bus(1'b1, rix(p, `DIO_OFF_IE), 8'h02);
    repeat (3) @(posedge sys_clk);
    chk8({6'h00, irq2, irq1}, 8'h00, "ie mask");
    bus(1'b1, rix(p, `DIO_OFF_IE), 8'h01);
    bus(1'b1, `DIO_GIE_IDX, 8'h00);
    repeat (3) @(posedge sys_clk);
    chk8({6'h00, irq2, irq1}, 8'h00, "gie mask");
    bus(1'b1, `DIO_GIE_IDX, 8'h01);
    bus(1'b1, rix(p, `DIO_OFF_IE), 8'h80);
    bus(1'b1, rix(p, `DIO_OFF_IFG), 8'h80);
    repeat (3) @(posedge sys_clk);
    chk8({6'h00, irq2, irq1}, me, "sw set");
    bus(1'b1, rix(p, `DIO_OFF_IFG), 8'h00);
  endtask : t_edges

  task automatic t_select;
    bus(1'b1, rix(0, `DIO_OFF_IES), 8'h00);
    bus(1'b1, rix(0, `DIO_OFF_IE), 8'h01);
    bus(1'b1, six(0), 8'h01);
    rdchk(rix(0, `DIO_OFF_DIR), 8'h00, "dir kept");
    bus(1'b1, rix(0, `DIO_OFF_DIR), 8'h01);
    repeat (2) @(posedge sys_clk);
    chk8(pad[0].level, 8'hA4, "periph drive");
    bus(1'b1, rix(0, `DIO_OFF_DIR), 8'h00);
    setx(0, 8'h01);
    chk8(pin_periph[0], 8'h01, "periph follow");
    rdchk(rix(0, `DIO_OFF_IFG), 8'h00, "sel no flag");
    chk8({6'h00, irq2, irq1}, 8'h00, "sel no irq");
    bus(1'b1, rix(0, `DIO_OFF_IFG), 8'h01);
    repeat (3) @(posedge sys_clk);
    chk8({6'h00, irq2, irq1}, 8'h00, "sel sw flag");
    bus(1'b1, rix(0, `DIO_OFF_IFG), 8'h00);
    bus(1'b1, six(0), 8'h00);
    setx(0, 8'h00);
    chk8(pin_periph[0], 8'h01, "periph hold");
  endtask : t_select

  task automatic t_dirflag;
    bus(1'b1, rix(1, `DIO_OFF_IES), 8'h00);
    bus(1'b1, rix(1, `DIO_OFF_IE), 8'h00);
    bus(1'b1, rix(1, `DIO_OFF_OUT), 8'h01);
    bus(1'b1, rix(1, `DIO_OFF_IFG), 8'h00);
    bus(1'b1, rix(1, `DIO_OFF_DIR), 8'h01);
    repeat (4) @(posedge sys_clk);
    rdchk(rix(1, `DIO_OFF_IFG), 8'h01, "dir write");
  endtask : t_dirflag

  // ==========================================================
  // verdict, watchdog and main sequence
  task automatic print_verdict;
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    print_verdict();
  end

  initial begin
    mismatches = 0;
    checks = 0;
    {rst_b, cyc, stb, we} = 4'h0;
    sel = 4'h0;
    adr = 32'h00000000;
    wdat = 32'h00000000;
    ext = '0;
    pout = '0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_ports();
    t_edges(0);
    t_edges(1);
    t_select();
    t_dirflag();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
